// ===== hw/ume_params.svh
// Purpose: Constants of the uncore event selector
// Assumes: Included by package and design
// Notes: Codes and masks are hardware encodings
`ifndef UME_PARAMS_SVH
`define UME_PARAMS_SVH

// ==========================================
// Event codes
`define UME_EV_CONFLICT 8'h25
`define UME_EV_BYPASS 8'h26
`define UME_EV_NORM_FULL 8'h27
`define UME_EV_ISOC_FULL 8'h28
`define UME_EV_BUSY 8'h29
`define UME_EV_NORM_OCC 8'h2a
`define UME_EV_ISOC_OCC 8'h2b

// ==========================================
// Unit masks
`define UME_UM_01 8'h01
`define UME_UM_02 8'h02
`define UME_UM_04 8'h04
`define UME_UM_07 8'h07
`define UME_UM_08 8'h08
`define UME_UM_10 8'h10
`define UME_UM_20 8'h20

// ==========================================
// Widths, reset values and conflict count limits
`define UME_INC_W 8
`define UME_INC_RST 8'h00
`define UME_CONFLICT_MAX 2'h3
`define UME_CONFLICT_MIN 2'h2

`endif

// ===== hw/ume_pkg.sv
// Purpose: Types of the uncore event selector
// Assumes: ume_params.svh holds the numbers
// Notes: One packed state struct
`include "ume_params.svh"
`default_nettype none

package ume_pkg;

	typedef logic [`UME_INC_W-1:0] ume_inc_type;

	typedef struct packed
	{
		ume_inc_type incr;
		logic hit;
	} ume_state_type;

endpackage : ume_pkg

`default_nettype wire

// ===== hw/ume_event_select.sv
// Purpose: Per-cycle increment for uncore home/memctl events
// Assumes: All status inputs come from uncore clock logic
// Notes: Increment is registered, one cycle behind status
//
// Functional notes
// RULE1 - 25H/01H: io hub tracker conflict cycles
// RULE2 - 25H/02H remote, 04H local conflict cycles
// RULE3 - At most three entries counted in conflict
// RULE4 - 26H/01H: count home logic bypass requests
// RULE5 - Local always bypasses; remote only reads
// RULE6 - 27H/01,02,04: normal queue full of reads
// RULE7 - 27H/08,10,20: normal queue full of writes
// RULE8 - 28H/01,02,04: isoc queue full of reads
// RULE9 - 28H/08,10,20: isoc queue full of writes
// RULE10 - 29H/01,02,04: read outstanding per channel
// RULE11 - 29H/08,10,20: write outstanding per channel
// RULE12 - 2AH/01,02,04: normal read occupancy
// RULE13 - 2BH/01,02,04: isoc read occupancy
// RULE14 - 2BH/07H: isoc read occupancy, all channels
// RULE15 - Occupancy adds entries; unknown pairs add zero
`include "ume_params.svh"
`default_nettype none

module ume_event_select
#(
	parameter int TRK_ENTRIES = 8,
	parameter int ADDR_W = 16,
	parameter int NQ_DEPTH = 8,
	parameter int HQ_DEPTH = 4
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Event selection
	input wire logic [7:0] event_code,
	input wire logic [7:0] unit_mask,
	// io hub tracker
	input wire logic [TRK_ENTRIES-1:0] io_hub_trk_valid,
	input wire logic [TRK_ENTRIES*ADDR_W-1:0] io_hub_trk_addr,
	// Remote tracker
	input wire logic [TRK_ENTRIES-1:0] remote_trk_valid,
	input wire logic [TRK_ENTRIES*ADDR_W-1:0] remote_trk_addr,
	// Local tracker
	input wire logic [TRK_ENTRIES-1:0] local_trk_valid,
	input wire logic [TRK_ENTRIES*ADDR_W-1:0] local_trk_addr,
	// Request handed to the memory controller
	input wire logic mc_req_valid,
	input wire logic mc_req_bypass,
	input wire logic mc_req_local,
	input wire logic mc_req_write,
	// Normal queues, channel c in slice c
	input wire logic [3*NQ_DEPTH-1:0] nq_valid,
	input wire logic [3*NQ_DEPTH-1:0] nq_write,
	// High priority isochronous queues
	input wire logic [3*HQ_DEPTH-1:0] hq_valid,
	input wire logic [3*HQ_DEPTH-1:0] hq_write,
	// Result
	output ume_pkg::ume_inc_type event_incr,
	output logic event_hit
);
	import ume_pkg::*;

	// ==========================================
	// Elaboration checks
	localparam int MAX_OCC = 3 * HQ_DEPTH;

	// Refused at elaboration, not at run time
	if (TRK_ENTRIES < 2 || ADDR_W < 1)
	begin : g_bad_trk
		$error("ume_event_select: bad tracker size");
	end
	if (NQ_DEPTH < 1 || HQ_DEPTH < 1)
	begin : g_bad_depth
		$error("ume_event_select: bad queue depth");
	end
	if (NQ_DEPTH >= (1 << `UME_INC_W) || MAX_OCC >= (1 << `UME_INC_W))
	begin : g_bad_occ
		$error("ume_event_select: occupancy exceeds increment width");
	end

	// ==========================================
	// Helpers

	// Entries sharing an address with another valid entry, capped
	function automatic logic [1:0] conflict_count
	(
		input logic [TRK_ENTRIES-1:0] v,
		input logic [TRK_ENTRIES*ADDR_W-1:0] a
	);
		logic [1:0] n;
		logic m;
		n = 2'h0;
		for (int i = 0; i < TRK_ENTRIES; i++)
		begin
			m = 1'b0;
			for (int j = 0; j < TRK_ENTRIES; j++)
			begin
				if (i != j && v[i] && v[j]
					&& a[i*ADDR_W +: ADDR_W] == a[j*ADDR_W +: ADDR_W])
				begin
					m = 1'b1;
				end
			end
			// Hardware never groups more than three in conflict
			if (m && n != `UME_CONFLICT_MAX) // RULE3
			begin
				n = n + 2'h1;
			end
		end
		return n;
	endfunction : conflict_count

	// Number of set bits, at increment width
	function automatic ume_inc_type ones
	(
		input logic [3*NQ_DEPTH+3*HQ_DEPTH-1:0] b
	);
		ume_inc_type n;
		n = '0;
		for (int i = 0; i < 3*NQ_DEPTH+3*HQ_DEPTH; i++)
		begin
			n = n + ume_inc_type'(b[i]);
		end
		return n;
	endfunction : ones

	// ==========================================
	// Per-channel conditions
	logic [2:0] nq_full_rd;
	logic [2:0] nq_full_wr;
	logic [2:0] hq_full_rd;
	logic [2:0] hq_full_wr;
	logic [2:0] busy_rd;
	logic [2:0] busy_wr;
	ume_inc_type nq_rd_occ [3];
	ume_inc_type hq_rd_occ [3];
	ume_inc_type hq_rd_occ_all;
	logic [3*NQ_DEPTH+3*HQ_DEPTH-1:0] pad;

	always_comb
	begin
		pad = '0;
		hq_rd_occ_all = '0;
		for (int c = 0; c < 3; c++)
		begin
			nq_full_rd[c] = &(nq_valid[c*NQ_DEPTH +: NQ_DEPTH]
				& ~nq_write[c*NQ_DEPTH +: NQ_DEPTH]); // RULE6
			nq_full_wr[c] = &(nq_valid[c*NQ_DEPTH +: NQ_DEPTH]
				& nq_write[c*NQ_DEPTH +: NQ_DEPTH]); // RULE7
			hq_full_rd[c] = &(hq_valid[c*HQ_DEPTH +: HQ_DEPTH]
				& ~hq_write[c*HQ_DEPTH +: HQ_DEPTH]); // RULE8
			hq_full_wr[c] = &(hq_valid[c*HQ_DEPTH +: HQ_DEPTH]
				& hq_write[c*HQ_DEPTH +: HQ_DEPTH]); // RULE9
			// Outstanding means held in either queue of the channel
			busy_rd[c] = |(nq_valid[c*NQ_DEPTH +: NQ_DEPTH]
				& ~nq_write[c*NQ_DEPTH +: NQ_DEPTH])
				| |(hq_valid[c*HQ_DEPTH +: HQ_DEPTH]
				& ~hq_write[c*HQ_DEPTH +: HQ_DEPTH]); // RULE10
			busy_wr[c] = |(nq_valid[c*NQ_DEPTH +: NQ_DEPTH]
				& nq_write[c*NQ_DEPTH +: NQ_DEPTH])
				| |(hq_valid[c*HQ_DEPTH +: HQ_DEPTH]
				& hq_write[c*HQ_DEPTH +: HQ_DEPTH]); // RULE11
			nq_rd_occ[c] = ones({pad[3*NQ_DEPTH+3*HQ_DEPTH-1:NQ_DEPTH],
				nq_valid[c*NQ_DEPTH +: NQ_DEPTH]
				& ~nq_write[c*NQ_DEPTH +: NQ_DEPTH]}); // RULE12
			hq_rd_occ[c] = ones({pad[3*NQ_DEPTH+3*HQ_DEPTH-1:HQ_DEPTH],
				hq_valid[c*HQ_DEPTH +: HQ_DEPTH]
				& ~hq_write[c*HQ_DEPTH +: HQ_DEPTH]}); // RULE13
			hq_rd_occ_all = hq_rd_occ_all + hq_rd_occ[c]; // RULE14
		end
	end

	// ==========================================
	// Tracker conflicts and bypass
	logic io_conflict;
	logic remote_conflict;
	logic local_conflict;
	logic bypass_ok;

	always_comb
	begin
		io_conflict = conflict_count(io_hub_trk_valid, io_hub_trk_addr)
			>= `UME_CONFLICT_MIN; // RULE1
		remote_conflict = conflict_count(remote_trk_valid, remote_trk_addr)
			>= `UME_CONFLICT_MIN; // RULE2
		local_conflict = conflict_count(local_trk_valid, local_trk_addr)
			>= `UME_CONFLICT_MIN; // RULE2
		// A remote write claiming bypass is not counted
		bypass_ok = mc_req_valid && mc_req_bypass
			&& (mc_req_local || !mc_req_write); // RULE5
	end

	// Channel index for masks 01/02/04 and 08/10/20
	function automatic logic [2:0] sel_lo(input logic [7:0] um);
		return {um == `UME_UM_04, um == `UME_UM_02, um == `UME_UM_01};
	endfunction : sel_lo

	function automatic logic [2:0] sel_hi(input logic [7:0] um);
		return {um == `UME_UM_20, um == `UME_UM_10, um == `UME_UM_08};
	endfunction : sel_hi

	// Held in a net, since a call result cannot be bit-selected
	logic [2:0] um_lo;
	assign um_lo = sel_lo(unit_mask);

	// ==========================================
	// Selection and state
	ume_state_type state_r;
	ume_state_type state_nxt;

	always_comb
	begin
		state_nxt = '0;
		state_nxt.incr = `UME_INC_RST;
		case (event_code)
			`UME_EV_CONFLICT:
			begin
				state_nxt.hit = |sel_lo(unit_mask);
				state_nxt.incr = ume_inc_type'(
					(um_lo[0] & io_conflict)
					| (um_lo[1] & remote_conflict)
					| (um_lo[2] & local_conflict)); // RULE1 RULE2
			end
			`UME_EV_BYPASS:
			begin
				state_nxt.hit = unit_mask == `UME_UM_01;
				state_nxt.incr = ume_inc_type'(state_nxt.hit & bypass_ok); // RULE4
			end
			`UME_EV_NORM_FULL:
			begin
				state_nxt.hit = |{sel_lo(unit_mask), sel_hi(unit_mask)};
				state_nxt.incr = ume_inc_type'(
					|(sel_lo(unit_mask) & nq_full_rd)
					| |(sel_hi(unit_mask) & nq_full_wr)); // RULE6 RULE7
			end
			`UME_EV_ISOC_FULL:
			begin
				state_nxt.hit = |{sel_lo(unit_mask), sel_hi(unit_mask)};
				state_nxt.incr = ume_inc_type'(
					|(sel_lo(unit_mask) & hq_full_rd)
					| |(sel_hi(unit_mask) & hq_full_wr)); // RULE8 RULE9
			end
			`UME_EV_BUSY:
			begin
				state_nxt.hit = |{sel_lo(unit_mask), sel_hi(unit_mask)};
				state_nxt.incr = ume_inc_type'(
					|(sel_lo(unit_mask) & busy_rd)
					| |(sel_hi(unit_mask) & busy_wr)); // RULE10 RULE11
			end
			`UME_EV_NORM_OCC:
			begin
				state_nxt.hit = |um_lo;
				for (int c = 0; c < 3; c++)
				begin
					if (um_lo[c])
					begin
						state_nxt.incr = nq_rd_occ[c]; // RULE12 RULE15
					end
				end
			end
			`UME_EV_ISOC_OCC:
			begin
				state_nxt.hit = |sel_lo(unit_mask) || unit_mask == `UME_UM_07;
				for (int c = 0; c < 3; c++)
				begin
					if (um_lo[c])
					begin
						state_nxt.incr = hq_rd_occ[c]; // RULE13 RULE15
					end
				end
				if (unit_mask == `UME_UM_07)
				begin
					state_nxt.incr = hq_rd_occ_all; // RULE14
				end
			end
			default:
			begin
				// Unsupported pairs add nothing
				state_nxt = '0; // RULE15
			end
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= '0;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
		end
	end

	assign event_incr = state_r.incr;
	assign event_hit = state_r.hit;

endmodule : ume_event_select

`default_nettype wire

// ===== verification/ume_event_select_properties.sv
// Purpose: Port assertions of the event selector
// Assumes: Bound into ume_event_select
// Notes: Output follows inputs by one enabled edge
`default_nettype none

module ume_event_select_properties
	import ume_pkg::*;
#(
	parameter int NQ_DEPTH = 8,
	parameter int HQ_DEPTH = 4
)
(
	// Clock and selection
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] event_code,
	input wire logic [7:0] unit_mask,
	// Status
	input wire logic mc_req_valid,
	input wire logic mc_req_bypass,
	input wire logic mc_req_local,
	input wire logic mc_req_write,
	input wire logic [3*NQ_DEPTH-1:0] nq_valid,
	input wire logic [3*NQ_DEPTH-1:0] nq_write,
	input wire logic [3*HQ_DEPTH-1:0] hq_valid,
	input wire logic [3*HQ_DEPTH-1:0] hq_write,
	// Result
	input wire ume_pkg::ume_inc_type event_incr,
	input wire logic event_hit
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic byp = mc_req_valid & mc_req_bypass & (mc_req_local | ~mc_req_write);
	wire logic m6 = unit_mask inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
	wire logic [NQ_DEPTH-1:0] r0 = nq_valid[NQ_DEPTH-1:0] & ~nq_write[NQ_DEPTH-1:0];
	wire logic rd0 = (|r0) | (|(hq_valid[HQ_DEPTH-1:0] & ~hq_write[HQ_DEPTH-1:0]));
	wire ume_inc_type no0 = 8'($countones(r0));
	wire ume_inc_type iso = 8'($countones(hq_valid & ~hq_write));
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	a_unknown_code: assert property (clk_en && !(event_code inside {[8'h25:8'h2b]}) |=>
		event_incr == 8'h00 && !event_hit) else $error("unsupported code gave output");
	a_bypass_count: assert property (clk_en && event_code == 8'h26 && unit_mask == 8'h01
		|=> event_hit && event_incr == 8'($past(byp))) else $error("bypass count wrong");
	a_remote_write: assert property (clk_en && event_code == 8'h26 && mc_req_valid
		&& !mc_req_local && mc_req_write |=> event_incr == 8'h00) else $error("remote write");
	a_conflict_flag: assert property (clk_en && event_code == 8'h25 |=>
		event_incr <= 8'h01) else $error("conflict increment above one");
	a_full_flag: assert property (clk_en && event_code inside {8'h27, 8'h28} |=>
		event_incr <= 8'h01 && event_hit == $past(m6)) else $error("full event wrong");
	a_busy_read: assert property (clk_en && event_code == 8'h29 && unit_mask == 8'h01
		|=> event_incr == 8'($past(rd0))) else $error("busy read wrong");
	a_norm_occ: assert property (clk_en && event_code == 8'h2a && unit_mask == 8'h01
		|=> event_incr == $past(no0)) else $error("normal occupancy wrong");
	a_isoc_all: assert property (clk_en && event_code == 8'h2b && unit_mask == 8'h07
		|=> event_incr == $past(iso)) else $error("isochronous sum wrong");
endmodule : ume_event_select_properties

`default_nettype wire

// ===== verification/ume_status_model.sv
// Purpose: Random tracker and queue status
// Assumes: Four tracker entries, two per queue
// Notes: Few addresses, so conflicts are common
`default_nettype none

module ume_status_model
(
	// Clock
	input wire logic clock,
	// Trackers
	output logic [3:0] io_hub_trk_valid,
	output logic [3:0] remote_trk_valid,
	output logic [3:0] local_trk_valid,
	output logic [63:0] io_hub_trk_addr,
	output logic [63:0] remote_trk_addr,
	output logic [63:0] local_trk_addr,
	// Requests and queues
	output logic mc_req_valid,
	output logic mc_req_bypass,
	output logic mc_req_local,
	output logic mc_req_write,
	output logic [5:0] nq_valid,
	output logic [5:0] nq_write,
	output logic [5:0] hq_valid,
	output logic [5:0] hq_write
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [63:0] am = {4{16'h0003}};
	initial
	forever
	begin
		{io_hub_trk_valid, remote_trk_valid, local_trk_valid} <= 12'($urandom);
		io_hub_trk_addr <= {$urandom, $urandom} & am;
		remote_trk_addr <= {$urandom, $urandom} & am;
		local_trk_addr <= {$urandom, $urandom} & am;
		{mc_req_valid, mc_req_bypass, mc_req_local, mc_req_write} <= 4'($urandom);
		{nq_valid, nq_write, hq_valid, hq_write} <= 24'($urandom);
		@(negedge clock);
	end
endmodule : ume_status_model

`default_nettype wire

// ===== verification/ume_event_select_tb.sv
// Purpose: Self-checking bench of the event selector
// Assumes: ume_status_model drives all status
// Notes: Two-entry queues make full cycles frequent
`default_nettype none

module ume_event_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ume_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b0;
	logic [7:0] event_code = 8'h00;
	logic [7:0] unit_mask = 8'h00;
	wire logic [3:0] io_hub_trk_valid, remote_trk_valid, local_trk_valid;
	wire logic [63:0] io_hub_trk_addr, remote_trk_addr, local_trk_addr;
	wire logic mc_req_valid, mc_req_bypass, mc_req_local, mc_req_write;
	wire logic [5:0] nq_valid, nq_write, hq_valid, hq_write;
	ume_inc_type event_incr;
	logic event_hit;
	wire logic [8:0] got = {event_hit, event_incr};
	logic [8:0] exp_q[$];
	logic [7:0] masks[8] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h08, 8'h10, 8'h20, 8'h3f};
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [8:0] last_e = 9'h000;
	always #50 clock = ~clock;
	ume_status_model u_ume_status_model
	(
		.clock(clock),
		.io_hub_trk_valid(io_hub_trk_valid),
		.remote_trk_valid(remote_trk_valid),
		.local_trk_valid(local_trk_valid),
		.io_hub_trk_addr(io_hub_trk_addr),
		.remote_trk_addr(remote_trk_addr),
		.local_trk_addr(local_trk_addr),
		.mc_req_valid(mc_req_valid),
		.mc_req_bypass(mc_req_bypass),
		.mc_req_local(mc_req_local),
		.mc_req_write(mc_req_write),
		.nq_valid(nq_valid),
		.nq_write(nq_write),
		.hq_valid(hq_valid),
		.hq_write(hq_write)
	);
	ume_event_select #(.TRK_ENTRIES(4), .ADDR_W(16), .NQ_DEPTH(2), .HQ_DEPTH(2))
		u_ume_event_select
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.event_code(event_code),
		.unit_mask(unit_mask),
		.io_hub_trk_valid(io_hub_trk_valid),
		.io_hub_trk_addr(io_hub_trk_addr),
		.remote_trk_valid(remote_trk_valid),
		.remote_trk_addr(remote_trk_addr),
		.local_trk_valid(local_trk_valid),
		.local_trk_addr(local_trk_addr),
		.mc_req_valid(mc_req_valid),
		.mc_req_bypass(mc_req_bypass),
		.mc_req_local(mc_req_local),
		.mc_req_write(mc_req_write),
		.nq_valid(nq_valid),
		.nq_write(nq_write),
		.hq_valid(hq_valid),
		.hq_write(hq_write),
		.event_incr(event_incr),
		.event_hit(event_hit)
	);
	// ==========================================
	// Reference
	function automatic logic conf(logic [3:0] v, logic [63:0] a);
		conf = 1'b0;
		for (int i = 0; i < 4; i++)
			for (int j = i + 1; j < 4; j++)
				if (v[i] && v[j] && a[i*16 +: 16] == a[j*16 +: 16])
					conf = 1'b1;
	endfunction : conf
	function automatic logic [8:0] exp_calc();
		int c;
		logic s3, wr, f;
		logic [1:0] qv, qw, pv, pw;
		ume_inc_type n;
		s3 = unit_mask inside {8'h01, 8'h02, 8'h04};
		wr = unit_mask inside {8'h08, 8'h10, 8'h20};
		c = (unit_mask[0] | unit_mask[3]) ? 0 : (unit_mask[1] | unit_mask[4]) ? 1 : 2;
		qv = nq_valid[c*2 +: 2];
		qw = nq_write[c*2 +: 2];
		pv = hq_valid[c*2 +: 2];
		pw = hq_write[c*2 +: 2];
		f = event_code inside {8'h27, 8'h28, 8'h29} ? s3 | wr : event_code == 8'h26 ?
			unit_mask == 8'h01 : event_code inside {8'h25, 8'h2a} ? s3 :
			event_code == 8'h2b ? s3 | unit_mask == 8'h07 : 1'b0;
		case (event_code)
			8'h25: n = 8'(c == 0 ? conf(io_hub_trk_valid, io_hub_trk_addr) : c == 1 ?
				conf(remote_trk_valid, remote_trk_addr) : conf(local_trk_valid, local_trk_addr));
			8'h26: n = 8'(mc_req_valid & mc_req_bypass & (mc_req_local | ~mc_req_write));
			8'h27: n = 8'(&qv & (wr ? &qw : ~|qw));
			8'h28: n = 8'(&pv & (wr ? &pw : ~|pw));
			8'h29: n = 8'((|(qv & (wr ? qw : ~qw))) | (|(pv & (wr ? pw : ~pw))));
			8'h2a: n = 8'($countones(qv & ~qw));
			8'h2b: n = 8'($countones(unit_mask == 8'h07 ? hq_valid & ~hq_write : {4'h0, pv & ~pw}));
			default: n = 8'h00;
		endcase
		return {f, f ? n : 8'h00};
	endfunction : exp_calc
	task automatic check_out(logic [8:0] e, logic [8:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR hit_incr expected %h seen %h", e, g);
		end
	endtask : check_out
	task automatic give_verdict();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// ==========================================
	// Monitor and stimulus
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			n_errors++;
			give_verdict();
		end
		else if (sys_rst)
		begin
			// Reset clears the outputs; a frozen cycle after it holds zero
			last_e = 9'h000;
			#1;
			check_out(9'h000, got);
		end
		else if (clk_en && exp_q.size() > 0)
		begin
			#1;
			last_e = exp_q.pop_front();
			check_out(last_e, got);
		end
		else if (!clk_en)
		begin
			// Enable low must freeze the last result
			#1;
			check_out(last_e, got);
		end
	end
	initial
	begin
		void'($urandom(86206));
		repeat (5) @(posedge clock);
		@(negedge clock);
		check_out(9'h000, got);
		// Sweep every code with every mask, then random pairs
		for (int k = 0; k < 3400; k++)
		begin
			event_code = k < 2880 ? 8'h24 + 8'(k / 320) : 8'($urandom_range(47, 32));
			unit_mask = k < 2880 ? masks[(k / 40) % 8] : masks[$urandom % 8];
			clk_en = ($urandom % 8) != 0;
			// Two-cycle reset in mid-run; no result is due while it stands
			sys_rst = k inside {[3000:3001]};
			#1;
			if (clk_en && !sys_rst)
				exp_q.push_back(exp_calc());
			@(negedge clock);
		end
		give_verdict();
	end
endmodule : ume_event_select_tb

bind ume_event_select ume_event_select_properties #(.NQ_DEPTH(NQ_DEPTH), .HQ_DEPTH(HQ_DEPTH))
	u_ume_event_select_properties
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.event_code(event_code),
		.unit_mask(unit_mask),
		.mc_req_valid(mc_req_valid),
		.mc_req_bypass(mc_req_bypass),
		.mc_req_local(mc_req_local),
		.mc_req_write(mc_req_write),
		.nq_valid(nq_valid),
		.nq_write(nq_write),
		.hq_valid(hq_valid),
		.hq_write(hq_write),
		.event_incr(event_incr),
		.event_hit(event_hit)
	);

`default_nettype wire
